// [testbench/btc_controller_bench.sv]
// Self-checking bench for the triac controller
`timescale 1ns/1ps
module btc_controller_bench;
  logic ref_clk = 1'b0, rst_n = 1'b0, ext_reset = 1'b0, supply_low = 1'b0;
  logic mode_force_on = 1'b0, mode_force_off = 1'b0, gate_seen = 1'b0;
  logic period_select_a = 1'b0, period_select_b = 1'b0;
  logic [5:0] setpoint_code = 6'h00;
  logic [15:0] pulse_extend_pin = 16'h0450; // Above the minimum, so the pin governs
  logic mains_positive_flag, mains_negative_flag, gate_sense, gate_drive_output, triac_on;
  logic [4:0] ref_level;
  int failures = 0, comparisons = 0, cycles = 0;
  btc_controller u_dut (.ref_clk, .rst_n, .ext_reset, .mains_positive_flag,
    .mains_negative_flag, .gate_sense, .setpoint_code, .mode_force_on, .mode_force_off,
    .period_select_a, .period_select_b, .supply_low, .pulse_extend_pin,
    .gate_drive_output, .triac_on, .ref_level);
  btc_mains_model u_mains (.ref_clk, .conducting(triac_on), .mains_positive_flag,
    .mains_negative_flag, .gate_sense);
  initial forever #50 ref_clk = ~ref_clk;
  // Watchdog and gate activity seen
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (gate_drive_output === 1'b1) gate_seen <= 1'b1;
    if (cycles == 90000) begin
      failures++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Apply inputs, then let six half cycles pass so odd runs can close
  task automatic set_in(input logic [5:0] sp, input logic on, input logic off, input logic lo);
    setpoint_code = sp;
    mode_force_on = on;
    mode_force_off = off;
    supply_low = lo;
    repeat (7200) @(negedge ref_clk);
  endtask
  task automatic t_full;
    set_in(6'h20, 1'b0, 1'b0, 1'b0);
    cmp({7'h00, triac_on}, 8'h01);
    cmp({7'h00, gate_seen}, 8'h01);
    cmp({7'h00, ref_level != 5'h1f}, 8'h01);
  endtask
  task automatic t_low;
    set_in(6'h00, 1'b0, 1'b0, 1'b0);
    cmp({6'h00, gate_drive_output, triac_on}, 8'h00);
  endtask
  task automatic t_mode;
    set_in(6'h00, 1'b1, 1'b0, 1'b0);
    cmp({7'h00, triac_on}, 8'h01);
    set_in(6'h14, 1'b0, 1'b1, 1'b0);
    cmp({7'h00, triac_on}, 8'h00);
  endtask
  task automatic t_supply;
    set_in(6'h14, 1'b0, 1'b0, 1'b1);
    cmp({7'h00, triac_on}, 8'h00);
    set_in(6'h14, 1'b0, 1'b0, 1'b0);
    cmp({7'h00, triac_on}, 8'h01);
  endtask
  // External reset in mid-run, applied in a gap between gate pulses
  task automatic t_ext;
    for (int i = 0; i < 3000 && gate_drive_output !== 1'b0; i++) @(negedge ref_clk);
    ext_reset = 1'b1;
    period_select_b = 1'b1;
    repeat (20) @(negedge ref_clk);
    cmp({2'b00, gate_drive_output, triac_on, ref_level}, 8'h1f);
    ext_reset = 1'b0;
    // Second strap tied: a level lasts 16 half cycles, so ten crossings leave it at the top
    repeat (12000) @(negedge ref_clk);
    cmp({3'b000, ref_level}, 8'h1f);
  endtask
  initial begin
    repeat (15) @(negedge ref_clk);
    cmp({2'b00, gate_drive_output, triac_on, ref_level}, 8'h1f);
    @(negedge ref_clk);
    rst_n = 1'b1;
    t_full;
    t_low;
    t_mode;
    t_supply;
    t_ext;
    give_verdict;
  end
endmodule

// [testbench/btc_controller_sva.sv]
// Port assertions for the triac controller
`timescale 1ns/1ps
module btc_controller_sva (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic ext_reset, // Reset pin
  input wire logic mains_positive_flag, // Flag
  input wire logic mains_negative_flag, // Flag
  input wire logic gate_sense, // Sense
  input wire logic [5:0] setpoint_code, // Setpoint
  input wire logic mode_force_on, // Mode
  input wire logic mode_force_off, // Mode
  input wire logic supply_low, // Supply
  input wire logic [15:0] pulse_extend_pin, // Width
  input wire logic gate_drive_output, // Gate
  input wire logic triac_on, // Run
  input wire logic [4:0] ref_level // Level
);
  logic zone_r;
  logic [7:0] hc_r;
  logic [15:0] w_r;
  wire zero = mains_positive_flag == mains_negative_flag;
  // Raw zero entries inside a run and gate high time; raw pins lead the sync flops
  always_ff @(posedge ref_clk) begin
    zone_r <= zero;
    if (!triac_on) hc_r <= 8'h00;
    else if (zero && !zone_r) hc_r <= hc_r + 8'h01;
    w_r <= gate_drive_output ? w_r + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge ref_clk); endclocking
  a_reset_quiet: assert property (
    !rst_n |=> !gate_drive_output && !triac_on && ref_level == 5'h1f) else $error("reset leak");
  a_run_odd: assert property (disable iff (!rst_n || ext_reset)
    $fell(triac_on) |-> hc_r[0]) else $error("even run");
  a_gate_width: assert property (disable iff (!rst_n || ext_reset)
    $fell(gate_drive_output) |-> w_r >= 16'h03e8 && w_r >= pulse_extend_pin)
    else $error("short gate");
  a_switch_at_zero: assert property (disable iff (!rst_n || ext_reset)
    $changed(triac_on) |-> $past(zero, 3)) else $error("switch off zero");
  a_first_pulse: assert property (disable iff (!rst_n || ext_reset)
    $rose(triac_on) |-> ##[0:4] gate_drive_output) else $error("no first pulse");
  a_sense_refire: assert property (disable iff (!rst_n || ext_reset)
    triac_on && $rose(gate_sense) && !zero |-> ##[1:8] gate_drive_output)
    else $error("no refire");
  a_supply_block: assert property (disable iff (!rst_n || ext_reset)
    $rose(triac_on) |-> !$past(supply_low, 3)) else $error("start on low supply");
  a_demand_start: assert property (disable iff (!rst_n || ext_reset)
    $rose(triac_on) |-> $past(mode_force_on, 3) ||
      (!$past(mode_force_off, 3) && $past(setpoint_code, 3) != 6'h00))
    else $error("start without demand");
endmodule
bind btc_controller btc_controller_sva u_sva (.ref_clk, .rst_n, .ext_reset,
  .mains_positive_flag, .mains_negative_flag, .gate_sense, .setpoint_code, .mode_force_on,
  .mode_force_off, .supply_low, .pulse_extend_pin, .gate_drive_output, .triac_on, .ref_level);

// [testbench/btc_mains_model.sv]
// Mains line and triac model: threshold flags and gate sense
`timescale 1ns/1ps
module btc_mains_model (
  input wire logic ref_clk, // Clock
  input wire logic conducting, // Triac carries current
  output logic mains_positive_flag, // Above upper threshold
  output logic mains_negative_flag, // Below lower threshold
  output logic gate_sense // Current zero is near
);
  int ph = 0;
  // Phase steps on the falling edge, away from the sampling edge
  always @(negedge ref_clk) begin
    ph <= (ph + 1) % 2400;
  end
  // Half cycles of 1200 clocks, the last 100 of each in the near-zero band
  assign mains_positive_flag = ph < 1100;
  assign mains_negative_flag = ph >= 1200 && ph < 2300;
  // Sense only while conducting, well before the band so no zero event clashes
  assign gate_sense = conducting && (ph % 1200) >= 1040 && (ph % 1200) < 1060;
endmodule

// [verilog/btc_cfg.svh]
// Constants of the burst-fire triac controller: timing, reset values, strap decoding
`ifndef BTC_CFG_SVH
`define BTC_CFG_SVH

`define BTC_CLK_MHZ 10
`define BTC_MIN_PULSE_US 100
`define BTC_MIN_PULSE_CYC (`BTC_MIN_PULSE_US * `BTC_CLK_MHZ)
`define BTC_LEVELS 32
`define BTC_REF_TOP 5'h1f
`define BTC_SETPOINT_W 6
`define BTC_EXT_W 16
// Mains half cycles spent on each reference level, one per strap setting
`define BTC_HC_STEP_AA 11'h002
`define BTC_HC_STEP_AB 11'h010
`define BTC_HC_STEP_BA 11'h080
`define BTC_HC_STEP_BB 11'h400

`endif

// [verilog/btc_controller.sv]
// Burst-fire triac controller: mains sync, reference staircase, odd/even run sequencing
`timescale 1ns/1ps
`include "btc_cfg.svh"
module btc_controller
  import btc_pkg::*;
(
  input wire logic ref_clk, // 10 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ext_reset, // External reset pin, active high, synchronised before use
  input wire logic mains_positive_flag, // Mains above upper threshold
  input wire logic mains_negative_flag, // Mains below lower threshold
  input wire logic gate_sense, // Gate voltage shows imminent current zero
  input wire logic [5:0] setpoint_code, // Setpoint, 0 floating/lowest, 32 full scale
  input wire logic mode_force_on, // Mode pin held high
  input wire logic mode_force_off, // Mode pin held low
  input wire logic period_select_a, // First period strap tied to negative rail
  input wire logic period_select_b, // Second period strap tied to negative rail
  input wire logic supply_low, // Supply too low for reliable operation
  input wire logic [15:0] pulse_extend_pin, // Extended gate pulse width in cycles
  output logic gate_drive_output, // Triac gate drive, active high
  output logic triac_on, // ON run in progress
  output logic [4:0] ref_level // Current reference staircase level
);

  localparam int SYNC_W = 31;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    btc_zone_t zone;
    btc_run_t run;
    logic has_run;
    logic last_pol;
    logic on_odd;
    logic off_odd;
    logic [10:0] hc_cnt;
    logic [4:0] ref_lvl;
    logic [1:0] period_sel;
    logic straps_ok;
    logic sense_d;
    logic fire;
    logic gate_out;
    logic [15:0] ext_cyc;
  } btc_state_t;

  btc_state_t st_r;
  btc_state_t st_nxt;

  btc_pulse_if pif ();

  // Two threshold flags to a three-way zone; both set is treated as near zero
  function automatic btc_zone_t btc_zone(input logic pos, input logic neg);
    if (pos && !neg) begin
      btc_zone = ZONE_POS;
    end else if (neg && !pos) begin
      btc_zone = ZONE_NEG;
    end else begin
      btc_zone = ZONE_ZERO;
    end
  endfunction

  // Half cycles per reference level for a strap setting
  function automatic logic [10:0] btc_step_len(input logic [1:0] sel);
    case (sel)
      2'b00: btc_step_len = `BTC_HC_STEP_AA;
      2'b01: btc_step_len = `BTC_HC_STEP_AB;
      2'b10: btc_step_len = `BTC_HC_STEP_BA;
      default: btc_step_len = `BTC_HC_STEP_BB;
    endcase
  endfunction

  // Synchronised pin values, read only from the second stage
  logic s_ext_rst;
  logic s_pos;
  logic s_neg;
  logic s_sense;
  logic [5:0] s_setpoint;
  logic s_force_on;
  logic s_force_off;
  logic s_sel_a;
  logic s_sel_b;
  logic s_supply_low;
  logic [15:0] s_ext;
  logic [SYNC_W-1:0] pins;

  assign pins = {ext_reset, mains_positive_flag, mains_negative_flag, gate_sense,
                 setpoint_code, mode_force_on, mode_force_off, period_select_a,
                 period_select_b, supply_low, pulse_extend_pin};
  // Setpoint and extension words may tear for one cycle; they are only used
  // at zero crossings or as a width, so a one-sample glitch is tolerable
  assign {s_ext_rst, s_pos, s_neg, s_sense, s_setpoint, s_force_on, s_force_off,
          s_sel_a, s_sel_b, s_supply_low, s_ext} = st_r.sync2;

  // Sequencer next state
  always_comb begin
    btc_zone_t zone_now;
    logic zev;
    logic new_pol;
    logic demand;
    logic stop_want;
    logic [10:0] step_len;
    zone_now = btc_zone(s_pos, s_neg);
    zev = (zone_now == ZONE_ZERO) && (st_r.zone != ZONE_ZERO);
    new_pol = (st_r.zone == ZONE_NEG); // Half about to start is opposite the last zone
    // Mode override beats setpoint; code 0 never beats a level, 32 beats them all
    demand = s_force_on ||
             (!s_force_off && (s_setpoint > {1'b0, st_r.ref_lvl}));
    stop_want = !demand || s_supply_low;
    step_len = btc_step_len(st_r.period_sel);

    st_nxt = st_r;
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.fire = 1'b0;
    st_nxt.zone = zone_now;
    st_nxt.sense_d = s_sense;
    st_nxt.ext_cyc = s_ext;
    st_nxt.gate_out = pif.gate;

    if (s_ext_rst) begin
      // External reset overrides everything except the input synchronisers and the ext_cyc width copy
      st_nxt.zone = ZONE_ZERO;
      st_nxt.run = RUN_OFF;
      st_nxt.has_run = 1'b0;
      st_nxt.last_pol = 1'b0;
      st_nxt.on_odd = 1'b0;
      st_nxt.off_odd = 1'b0;
      st_nxt.hc_cnt = 11'h000;
      st_nxt.ref_lvl = `BTC_REF_TOP;
      st_nxt.straps_ok = 1'b0;
      st_nxt.period_sel = 2'b00;
      st_nxt.sense_d = 1'b0;
      st_nxt.gate_out = 1'b0;
    end else if (zev) begin
      // Straps are wired once; latch them at the first crossing after reset
      if (!st_r.straps_ok) begin
        st_nxt.period_sel = {s_sel_a, s_sel_b};
        st_nxt.straps_ok = 1'b1;
      end
      // Staircase walks 31 down to 0 then wraps, 32 levels per period
      if (st_r.hc_cnt >= step_len - 11'h001) begin
        st_nxt.hc_cnt = 11'h000;
        st_nxt.ref_lvl = st_r.ref_lvl - 5'h01;
      end else begin
        st_nxt.hc_cnt = st_r.hc_cnt + 11'h001;
      end
      case (st_r.run)
        RUN_OFF: begin
          st_nxt.off_odd = !st_r.off_odd;
          // Even OFF count completed and polarity flipped since the last run
          if (!stop_want && !st_r.off_odd &&
              (!st_r.has_run || new_pol != st_r.last_pol)) begin
            st_nxt.run = RUN_ON;
            st_nxt.on_odd = 1'b1;
            st_nxt.last_pol = new_pol;
            st_nxt.fire = 1'b1;
          end
        end
        RUN_ON: begin
          if (stop_want && st_r.on_odd) begin
            st_nxt.run = RUN_OFF;
            // The half cycle now starting is already the first OFF one
            st_nxt.off_odd = 1'b1;
            st_nxt.has_run = 1'b1;
          end else begin
            st_nxt.on_odd = !st_r.on_odd;
            st_nxt.last_pol = new_pol;
          end
        end
        default: begin
          st_nxt.run = RUN_OFF;
        end
      endcase
    end else if (st_r.run == RUN_ON && s_sense && !st_r.sense_d) begin
      // Re-fire before the current dies; after a stop the run is OFF and the
      // triac is left to extinguish at its own current zero
      st_nxt.fire = 1'b1;
    end
  end

  // State register; rst_n clears synchronisers too
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.zone <= ZONE_ZERO;
      st_r.run <= RUN_OFF;
      st_r.ref_lvl <= `BTC_REF_TOP;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pif.fire = st_r.fire;
  assign pif.ext_cycles = st_r.ext_cyc;

  // Pulse timer is held whenever either reset is active
  btc_gate_pulse u_pulse (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hold(s_ext_rst),
    .pif(pif)
  );

  // Outputs straight from flops
  assign gate_drive_output = st_r.gate_out;
  assign triac_on = (st_r.run == RUN_ON);
  assign ref_level = st_r.ref_lvl;

endmodule

// [verilog/btc_gate_pulse.sv]
// Gate pulse timer: stretches a fire request to max(minimum, extension) cycles
`timescale 1ns/1ps
`include "btc_cfg.svh"
module btc_gate_pulse
  import btc_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic hold, // Sequencing reset, kills any pulse
  btc_pulse_if.gen pif // Fire request in, gate level out
);

  typedef struct packed {
    logic [15:0] cnt;
    logic gate;
  } btc_pulse_st_t;

  btc_pulse_st_t st_r;
  btc_pulse_st_t st_nxt;

  // Larger of two cycle counts
  function automatic logic [15:0] btc_max16(input logic [15:0] a, input logic [15:0] b);
    btc_max16 = (a > b) ? a : b;
  endfunction

  localparam logic [15:0] MIN_CYC = 16'(`BTC_MIN_PULSE_CYC);

  // A fire during a pulse restarts the full width, so a retrigger is never shortened
  always_comb begin
    st_nxt = st_r;
    if (hold) begin
      st_nxt = '0;
    end else if (pif.fire) begin
      st_nxt.cnt = btc_max16(MIN_CYC, pif.ext_cycles);
      st_nxt.gate = 1'b1;
    end else if (st_r.cnt > 16'h0001) begin
      st_nxt.cnt = st_r.cnt - 16'h0001;
    end else begin
      st_nxt.cnt = 16'h0000;
      st_nxt.gate = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pif.gate = st_r.gate;

endmodule

// [verilog/btc_pkg.sv]
// Types shared by the triac controller modules
package btc_pkg;

  typedef enum logic [1:0] {ZONE_NEG, ZONE_ZERO, ZONE_POS} btc_zone_t;
  typedef enum logic {RUN_OFF, RUN_ON} btc_run_t;

endpackage

// [verilog/btc_pulse_if.sv]
// Carrier between the sequencer and the gate pulse timer
`timescale 1ns/1ps
interface btc_pulse_if;
  logic fire;
  logic [15:0] ext_cycles;
  logic gate;
  modport ctrl (output fire, output ext_cycles, input gate);
  modport gen (input fire, input ext_cycles, output gate);
endinterface
